// ---- hdl/spfp_map.vh ----
// Purpose: Register offsets, field positions and reset values of the fast-path pin select.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by the top-level design file by bare name.
`ifndef SPFP_MAP_VH
`define SPFP_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPFP_OFS_PB_GRP 8'h00
`define SPFP_OFS_PB_OPT 8'h04
`define SPFP_OFS_PC_GRP 8'h08
`define SPFP_OFS_PC_OPT 8'h0C
`define SPFP_OFS_STATUS 8'h10
`define SPFP_ADDR_W 8

// ----------------------------------------------------------------
// Reset values and field constants
// ----------------------------------------------------------------
`define SPFP_SEL_RESET 32'h00000000
`define SPFP_FAST_CODE 2'h3
`define SPFP_NPINS 12
`define SPFP_NINST 3
`define SPFP_PINS_PER_INST 4

// Bank of each pin: 0 = port B high bank, 1 = port C low bank (bit per pin index).
`define SPFP_BANK_MAP 12'hFE0

// Low bit of each pin's 2-bit field, five bits per pin, pin 0 in the low bits.
// Pins 0-3 instance A (20,22,24,26), 4-7 instance B (30,0,2,4), 8-11 instance C (10..16).
`define SPFP_LSB_MAP 60'h8398A2081ED62D4
`define SPFP_LSB_W 5

// Status register layout.
`define SPFP_ST_ENG_LSB 0
`define SPFP_ST_MISUSE_LSB 16
`endif

// ---- hdl/spfp_pin_cell.v ----
// Purpose: One pin of the fast-path select: output steering and filtered input return.
// Assumes: pin_in is asynchronous to pclk; the other inputs are pclk logic.
// Notes:   All outputs are registered.
`timescale 1ns/10ps
`default_nettype none

module spfp_pin_cell
(
    // Clock, reset and enable.
    input wire pclk,
    input wire presetn,
    input wire pce,
    // Steering select.
    input wire sel_fast,
    // Serial interface side.
    input wire spi_out,
    input wire spi_oe,
    output reg spi_in,
    // Other pin function side.
    input wire alt_out,
    input wire alt_oe,
    output reg alt_in,
    // Chip pin.
    input wire pin_in,
    output reg pin_out,
    output reg pin_oe
);

    reg sync1;
    reg sync2;
    reg sync3;
    reg pin_level;

    // ----------------------------------------------------------------
    // Input synchroniser and filter
    // ----------------------------------------------------------------
    // Only sync2 and sync3 are compared; sync1 feeds sync2 alone to keep metastability contained.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            pin_level <= 1'b0;
        end
        else if (pce)
        begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3)
            begin
                pin_level <= sync3;
            end
        end
    end

    // ----------------------------------------------------------------
    // Steering
    // ----------------------------------------------------------------
    // The serial unit sees the pin only while the fast path is engaged; for the first five edges
    // after engaging, spi_in still carries the filtered level from before the switch.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            spi_in <= 1'b0;
            alt_in <= 1'b0;
        end
        else if (pce)
        begin
            if (sel_fast)
            begin
                pin_out <= spi_out;
                pin_oe <= spi_oe;
                spi_in <= pin_level;
                alt_in <= 1'b0;
            end
            else
            begin
                pin_out <= alt_out;
                pin_oe <= alt_oe;
                spi_in <= 1'b0;
                alt_in <= pin_level;
            end
        end
    end

endmodule // spfp_pin_cell

`default_nettype wire

// ---- hdl/spfp_top.v ----
// Purpose: Fast-path pin select for three serial interface instances, four pins each.
// Assumes: APB slave at 100 MHz; pins are split into input, output and output enable.
// Notes:   Pin index n: A 0-3, B 4-7, C 8-11; order data out, data in, clock, select.
//          Status word: engaged pins in the low bits, sticky misuse flags above them.
//          The fast mode bits must come from pclk logic; they are not synchronised.
//          Pins of an unselected instance keep their other function untouched.
//
// How it works
// - One fast pin option per serial instance.
// - Instance A uses port B high fields.
// - Instance B spans port B and C fields.
// - Instance C uses port C low fields.
// - Fast path works regardless of fast mode.
`timescale 1ns/10ps
`default_nettype none
`include "spfp_map.vh"

module spfp_top
(
    // Clock, reset and enable.
    input wire pclk,
    input wire presetn,
    input wire pce,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Serial interface units, one bit per pin index; fast mode one bit per instance.
    input wire [11:0] spi_out,
    input wire [11:0] spi_oe,
    output wire [11:0] spi_in,
    input wire [2:0] fast_mode_bit,
    // Other pin functions selected by the same fields.
    input wire [11:0] alt_out,
    input wire [11:0] alt_oe,
    output wire [11:0] alt_in,
    // Chip pins.
    input wire [11:0] pin_in,
    output wire [11:0] pin_out,
    output wire [11:0] pin_oe
);

    // Selector registers, status flags and bus decode.
    reg [31:0] portb_hi_group_select;
    reg [31:0] portb_hi_option_select;
    reg [31:0] portc_lo_group_select;
    reg [31:0] portc_lo_option_select;
    reg [2:0] misuse;
    wire [11:0] engaged;
    wire [2:0] inst_fast;
    wire [7:0] addr;
    wire access;
    reg [31:0] next_rdata;
    reg next_err;
    wire start;
    wire [2:0] clear_mask;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    // A pin engages only when both its group and its option field read the fast code.
    // Requiring both fields keeps a half-programmed pin on its other function, so a
    // pin never flips to the fast path in the middle of a two-write update.
    function fast_sel;
        input [31:0] grp;
        input [31:0] opt;
        input [4:0] lsb;
        begin
            fast_sel = (grp[lsb +: 2] == `SPFP_FAST_CODE) && (opt[lsb +: 2] == `SPFP_FAST_CODE);
        end
    endfunction

    // Per-pin tables: which bank holds the fields, and where each field starts.
    localparam [11:0] BANK = `SPFP_BANK_MAP;
    localparam [59:0] LSBS = `SPFP_LSB_MAP;

    genvar gi;
    generate
        for (gi = 0; gi < `SPFP_NPINS; gi = gi + 1)
        begin : g_pin
            // Bank and field position per pin give the instance A, B, C maps.
            assign engaged[gi] = BANK[gi] ?
                fast_sel(portc_lo_group_select, portc_lo_option_select,
                         LSBS[gi*`SPFP_LSB_W +: `SPFP_LSB_W]) :
                fast_sel(portb_hi_group_select, portb_hi_option_select,
                         LSBS[gi*`SPFP_LSB_W +: `SPFP_LSB_W]);

            // The fast mode bit is deliberately not an input to steering.
            // Returns pass a three-stage filter, so a pin change reaches the serial unit
            // five edges later; the serial units must budget for that latency.
            spfp_pin_cell u_cell
            (
                .pclk(pclk),
                .presetn(presetn),
                .pce(pce),
                .sel_fast(engaged[gi]),
                .spi_out(spi_out[gi]),
                .spi_oe(spi_oe[gi]),
                .spi_in(spi_in[gi]),
                .alt_out(alt_out[gi]),
                .alt_oe(alt_oe[gi]),
                .alt_in(alt_in[gi]),
                .pin_in(pin_in[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi])
            );
        end
        for (gi = 0; gi < `SPFP_NINST; gi = gi + 1)
        begin : g_inst
            // An instance counts as fast only with all four of its pins engaged.
            // A partly engaged instance would split its signals across two paths.
            assign inst_fast[gi] = &engaged[gi*`SPFP_PINS_PER_INST +: `SPFP_PINS_PER_INST];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Fast mode without fast pins
    // ----------------------------------------------------------------
    // Sticky flag: fast mode seen while the instance lacks the fast path; cleared by a status
    // write of one, and a new occurrence in the clearing cycle wins.
    // The flag only reports; steering is left alone so normal transfers still work.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            misuse <= 3'h0;
        end
        else if (pce)
        begin
            misuse <= (misuse & ~clear_mask) | (fast_mode_bit & ~inst_fast);
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state: pready rises a cycle into the access phase, and the write lands on the
    // edge where the master sees it high. This keeps every bus output registered.
    // The cost is one extra cycle per access, which configuration traffic never notices.
    assign addr = paddr[`SPFP_ADDR_W-1:0];
    assign access = psel && penable && pready;

    // The first cycle of an access phase starts the single wait state.
    assign start = psel && penable && !pready;

    // Writing ones to the status word clears misuse flags; a refused transfer clears none.
    assign clear_mask = (access && pwrite && !pslverr && addr == `SPFP_OFS_STATUS) ?
                        pwdata[`SPFP_ST_MISUSE_LSB +: `SPFP_NINST] : 3'h0;

    // Read data and error for the current address.
    // Reserved status bits and refused reads return zero.
    always @*
    begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (paddr[31:`SPFP_ADDR_W] != 24'h000000 || paddr[1:0] != 2'h0)
        begin
            next_err = 1'b1;
        end
        else
        begin
            case (addr)
                `SPFP_OFS_PB_GRP: next_rdata = portb_hi_group_select;
                `SPFP_OFS_PB_OPT: next_rdata = portb_hi_option_select;
                `SPFP_OFS_PC_GRP: next_rdata = portc_lo_group_select;
                `SPFP_OFS_PC_OPT: next_rdata = portc_lo_option_select;
                `SPFP_OFS_STATUS:
                begin
                    next_rdata[`SPFP_ST_ENG_LSB +: `SPFP_NPINS] = engaged;
                    next_rdata[`SPFP_ST_MISUSE_LSB +: `SPFP_NINST] = misuse;
                end
                default: next_err = 1'b1;
            endcase
        end
    end

    // Handshake, read capture and register writes.
    // With pce low the handshake freezes too; a low pready lengthens the wait, but a high pready stays high and that cycle's write is dropped.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            portb_hi_group_select <= `SPFP_SEL_RESET;
            portb_hi_option_select <= `SPFP_SEL_RESET;
            portc_lo_group_select <= `SPFP_SEL_RESET;
            portc_lo_option_select <= `SPFP_SEL_RESET;
        end
        else if (pce)
        begin
            pready <= start;
            pslverr <= start && next_err;
            if (start && !pwrite)
            begin
                prdata <= next_err ? 32'h00000000 : next_rdata;
            end
            if (access && pwrite && !pslverr)
            begin
                // Status writes land in the misuse clear logic above.
                case (addr)
                    `SPFP_OFS_PB_GRP: portb_hi_group_select <= pwdata;
                    `SPFP_OFS_PB_OPT: portb_hi_option_select <= pwdata;
                    `SPFP_OFS_PC_GRP: portc_lo_group_select <= pwdata;
                    `SPFP_OFS_PC_OPT: portc_lo_option_select <= pwdata;
                    default: ;
                endcase
            end
        end
    end

endmodule // spfp_top

`default_nettype wire

// ---- testbench/spfp_pin_model.sv ----
// Purpose: Chip pin wires at the far side of the fast-path select.
// Assumes: Outside drivers are weak and lose to an enabled pin driver.
// Notes: Level is resolved per pin.
`timescale 1ns/10ps
`default_nettype none
module spfp_pin_model
(
    // Pin drive and outside level.
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] ext_lvl,
    // Resolved wire level.
    output logic [11:0] pin_lvl
);
    // An enabled driver wins, so the select sees its own drive back.
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // spfp_pin_model
`default_nettype wire

// ---- testbench/spfp_checker.sv ----
// Purpose: Port checks of the fast-path select.
// Assumes: Bound to spfp_top.
// Notes: Steering itself is judged by the bench model.
`timescale 1ns/10ps
`default_nettype none
module spfp_checker
(
    // Clock and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pin paths.
    input wire logic [11:0] spi_out,
    input wire logic [11:0] spi_oe,
    input wire logic [11:0] spi_in,
    input wire logic [11:0] alt_out,
    input wire logic [11:0] alt_oe,
    input wire logic [11:0] alt_in,
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (psel && penable && !pready && pce |=> pready)
        else $error("pready missing after access");
    a_ready_pulse: assert property (pready && pce |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data not zero");
    a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("prdata moved outside a read");
    a_out_source: assert property ($past(pce) |->
        ((pin_out ^ $past(spi_out)) & (pin_out ^ $past(alt_out))) == 12'h000)
        else $error("pin_out from no source");
    a_oe_source: assert property ($past(pce) |->
        ((pin_oe ^ $past(spi_oe)) & (pin_oe ^ $past(alt_oe))) == 12'h000)
        else $error("pin_oe from no source");
    a_return_split: assert property ((spi_in & alt_in) == 12'h000)
        else $error("pin returned to both sides");
endmodule // spfp_checker
bind spfp_top spfp_checker chk (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench of the fast-path select.
// Assumes: One wait state per APB access.
// Notes: Random select words; a bench model predicts steering.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, seed, rd, gb, ob, gc, oc, all;
    logic [11:0] spi_out, spi_oe, spi_in, alt_out, alt_oe, alt_in;
    logic [11:0] pin_in, pin_out, pin_oe, ext_lvl, eng, drv, oe_x;
    logic [2:0] fast_mode_bit;
    integer err_total, total_checks, n;
    int lsb[12] = '{20, 22, 24, 26, 30, 0, 2, 4, 10, 12, 14, 16};

    spfp_top uut (.*);
    spfp_pin_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_lvl(pin_in));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Xorshift source; a fixed start keeps runs repeatable.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // A pin is fast only when both of its fields read 11b.
    function automatic logic [11:0] engaged();
        logic [11:0] e;
        for (int i = 0; i < 12; i++)
            e[i] = (i < 5) ? (gb[lsb[i] +: 2] == 2'h3 && ob[lsb[i] +: 2] == 2'h3)
                : (gc[lsb[i] +: 2] == 2'h3 && oc[lsb[i] +: 2] == 2'h3);
        return e;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; waits for pready, and only the watchdog ends a hung wait.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {spi_out, spi_oe, alt_out, alt_oe, ext_lvl, fast_mode_bit} = '0;
        pce = 1'b1;
        presetn = 1'b0;
        seed = 32'h00015E4B;
        err_total = 0;
        total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then an unmapped and a misaligned access.
        for (n = 0; n < 5; n++)
        begin
            apb(1'b0, n * 4, 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 32'h14, 32'h0);
        check(rd, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 32'h02, 32'hFFFFFFFF);
        check(err, 1'b1);
        apb(1'b0, 32'h0, 32'h0);
        check(rd, 32'h0);
        check(err, 1'b0);
        $display("test reset and refusal done");
        // Random selector words; the first two engage every pin.
        for (n = 0; n < 60; n++)
        begin
            all = {32{n < 2}};
            gb = rnd() | rnd() | all;
            ob = rnd() | rnd() | all;
            gc = rnd() | rnd() | all;
            oc = rnd() | rnd() | all;
            spi_out <= rnd();
            spi_oe <= rnd();
            alt_out <= rnd();
            alt_oe <= rnd();
            fast_mode_bit <= 3'h0;
            apb(1'b1, 32'h0, gb);
            apb(1'b1, 32'h4, ob);
            apb(1'b1, 32'h8, gc);
            apb(1'b1, 32'hC, oc);
            // Clear leftover misuse flags, then raise fast mode bits at random.
            apb(1'b1, 32'h10, 32'h00070000);
            fast_mode_bit <= rnd();
            repeat (4) @(posedge pclk);
            eng = engaged();
            drv = (spi_out & eng) | (alt_out & ~eng);
            oe_x = (spi_oe & eng) | (alt_oe & ~eng);
            check(pin_out, drv);
            check(pin_oe, oe_x);
            apb(1'b0, 32'h10, 32'h0);
            check(rd[11:0], eng);
            check(rd[18:16], fast_mode_bit & ~{&eng[11:8], &eng[7:4], &eng[3:0]});
            ext_lvl <= rnd();
            repeat (6) @(posedge pclk);
            check(spi_in, ((oe_x & drv) | (~oe_x & ext_lvl)) & eng);
            check(alt_in, ((oe_x & drv) | (~oe_x & ext_lvl)) & ~eng);
        end
        $display("test random steering done");
        stop_test();
    end

    // Watchdog well beyond the expected run length.
    initial
    begin
        #200000;
        err_total++;
        stop_test();
    end
endmodule // testbench
`default_nettype wire
